//--- sdclk_bank.sv
// raw interrupt clear and card serial clock generator behind apb
`timescale 1ns/100ps
`include "sdclk_defs.svh"

module sdclk_bank
  import sdclk_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [`SDCLK_NUM_SRC-1:0] src_event_i,
  output logic [`SDCLK_NUM_SRC-1:0] raw_irq_o,
  output logic card_irq_o,
  output logic card_clk_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic acc_w;
  logic wr_w;
  logic [`SDCLK_NUM_SRC-1:0] raw_ff;
  logic [`SDCLK_NUM_SRC-1:0] mask_ff;
  logic [31:0] rate_ff;
  logic [`SDCLK_NUM_EV-1:0] st_ff;
  logic [`SDCLK_NUM_EV-1:0] en_ff;
  logic [`SDCLK_NUM_SRC-1:0] clr_w;
  logic [15:0] cnt_ff;
  logic [15:0] div_w;
  logic gate_w;
  sdclk_state_e state_ff;
  logic [31:0] nxt_rdata;
  logic nxt_err;

  // single-cycle access phase: pready is registered high only for the first access cycle
  assign acc_w = psel_i & penable_i;
  assign wr_w = acc_w & pwrite_i;
  assign div_w = rate_ff[`SDCLK_DIV_MSB:0];
  assign gate_w = rate_ff[`SDCLK_GATE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // raw interrupt latches and write-one clear
  // only the low 18 positions carry a clear strobe
  generate
    genvar gi;
    for (gi = 0; gi < `SDCLK_NUM_SRC; gi = gi + 1) begin : g_clr
      if (gi < `SDCLK_NUM_CLR) begin : g_on
        assign clr_w[gi] = wr_w & (paddr_i == `SDCLK_OFS_IRQ_CLEAR) &
                           pwdata_i[gi];
      end else begin : g_off
        assign clr_w[gi] = 1'b0;
      end
    end
  endgenerate

  // set wins over clear so an event in the clear cycle survives
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_ff <= '0;
    end else begin
      raw_ff <= (raw_ff & ~clr_w) | src_event_i;
    end
  end

  // mask register, reset all masked
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_ff <= `SDCLK_MASK_RST;
    end else if (wr_w && paddr_i == `SDCLK_OFS_IRQ_MASK) begin
      mask_ff <= pwdata_i[`SDCLK_NUM_SRC-1:0];
    end
  end

  // raw view and masked card interrupt, registered
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_irq_o <= '0;
      card_irq_o <= 1'b0;
    end else begin
      raw_irq_o <= raw_ff;
      card_irq_o <= |(raw_ff & ~mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock rate register; a gating write also loads the divider field from pwdata_i[15:0]
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_ff <= `SDCLK_RATE_RST;
    end else if (wr_w && paddr_i == `SDCLK_OFS_CLK_RATE) begin
      rate_ff <= {pwdata_i[31], 15'h0, pwdata_i[15:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock generator: high for div/2, low for div-div/2 cycles
  // a divider below two is refused: the line stays low, and while ungated a flag is set
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= SDCLK_GATED;
      cnt_ff <= 16'h0000;
      card_clk_o <= 1'b0;
    end else if (gate_w || div_w < `SDCLK_DIV_MIN) begin
      state_ff <= SDCLK_GATED;
      cnt_ff <= 16'h0000;
      card_clk_o <= 1'b0;
    end else begin
      case (state_ff)
        SDCLK_GATED: begin
          state_ff <= SDCLK_HIGH;
          cnt_ff <= 16'h0001;
          card_clk_o <= 1'b1;
        end
        SDCLK_HIGH: begin
          if (cnt_ff >= (div_w >> 1)) begin
            state_ff <= SDCLK_LOW;
            cnt_ff <= 16'h0001;
            card_clk_o <= 1'b0;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        SDCLK_LOW: begin
          if (cnt_ff >= div_w - (div_w >> 1)) begin
            state_ff <= SDCLK_HIGH;
            cnt_ff <= 16'h0001;
            card_clk_o <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        default: begin
          state_ff <= SDCLK_GATED;
          cnt_ff <= 16'h0000;
          card_clk_o <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // block events: gate entered, invalid divider while ungated
  // write one clears a status bit; a new event wins over the clear
  logic [`SDCLK_NUM_EV-1:0] ev_w;
  logic [`SDCLK_NUM_EV-1:0] st_clr_w;
  logic gate_d_ff;
  assign ev_w[`SDCLK_EV_GATE] = gate_w & ~gate_d_ff;
  assign ev_w[`SDCLK_EV_BADDIV] = ~gate_w & (div_w < `SDCLK_DIV_MIN);
  assign st_clr_w = (wr_w && paddr_i == `SDCLK_OFS_IRQ_STATUS) ?
                    pwdata_i[`SDCLK_NUM_EV-1:0] : '0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_d_ff <= 1'b1;
      st_ff <= '0;
    end else begin
      gate_d_ff <= gate_w;
      st_ff <= (st_ff & ~st_clr_w) | ev_w;
    end
  end

  // event enable register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_ff <= '0;
    end else if (wr_w && paddr_i == `SDCLK_OFS_IRQ_ENABLE) begin
      en_ff <= pwdata_i[`SDCLK_NUM_EV-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((st_ff & ~st_clr_w | ev_w) & en_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses answer with pslverr and zero data
  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    if (paddr_i == `SDCLK_OFS_IRQ_RAW) begin
      nxt_rdata = {13'h0, raw_ff};
    end else if (paddr_i == `SDCLK_OFS_IRQ_MASK) begin
      nxt_rdata = {13'h0, mask_ff};
    end else if (paddr_i == `SDCLK_OFS_IRQ_CLEAR) begin
      nxt_rdata = 32'h00000000;
    end else if (paddr_i == `SDCLK_OFS_CLK_RATE) begin
      nxt_rdata = rate_ff;
    end else if (paddr_i == `SDCLK_OFS_IRQ_STATUS) begin
      nxt_rdata = {30'h0, st_ff};
    end else if (paddr_i == `SDCLK_OFS_IRQ_ENABLE) begin
      nxt_rdata = {30'h0, en_ff};
    end else begin
      nxt_err = 1'b1;
    end
  end

  // answer registered in setup, valid through the access phase
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
      pready_o <= 1'b0;
    end else begin
      prdata_o <= (psel_i && !pwrite_i) ? nxt_rdata : 32'h00000000;
      pslverr_o <= psel_i & ~penable_i & nxt_err;
      pready_o <= psel_i & ~penable_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks on the raw latches and the write-one clear
  clr_bit_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    clr_w[0] && !src_event_i[0] |=> !raw_ff[0])
    else $error("raw bit 0 not cleared");
  set_win_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    src_event_i[0] |=> raw_ff[0])
    else $error("raw event lost in clear cycle");
  clr_top_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    raw_ff[18] && wr_w && paddr_i == `SDCLK_OFS_IRQ_CLEAR |=> raw_ff[18])
    else $error("bit 18 cleared");
  rd_clr_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    psel_i && !penable_i && paddr_i == `SDCLK_OFS_IRQ_CLEAR
    |=> prdata_o == 32'h00000000)
    else $error("clear register read not zero");
  clr_zero_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    raw_ff[3] && !clr_w[3] |=> raw_ff[3])
    else $error("raw bit lost without clear");

  // checks on the card serial clock
  gate_low_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    gate_w [*2] |-> !card_clk_o)
    else $error("clock runs while gated");
  gate_now_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    gate_w |=> !card_clk_o)
    else $error("clock not stopped one cycle after gating");
  // phase checks skip cycles in which software rewrites the rate
  div_four_hi_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(card_clk_o) && div_w == 16'h0004 && !gate_w ##1 $stable(rate_ff)
    |-> card_clk_o ##1 !card_clk_o)
    else $error("high phase of divide by four wrong");
  div_four_lo_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(card_clk_o) && $stable(rate_ff) && div_w == 16'h0004 && !gate_w
    ##1 $stable(rate_ff) |-> !card_clk_o ##1 card_clk_o)
    else $error("low phase of divide by four wrong");
  div_per_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(card_clk_o) && div_w == 16'h0002 && !gate_w ##1 $stable(rate_ff)
    |-> !card_clk_o ##1 card_clk_o)
    else $error("divide by two wrong");
  keep_div_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(gate_w) |-> div_w == $past(div_w))
    else $error("divider lost on gating");

  // checks on masking, reset values and the bus answer
  mask_irq_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (raw_ff & ~mask_ff) == '0 |=> !card_irq_o)
    else $error("masked source reached output");
  mask_pass_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (raw_ff & ~mask_ff) != '0 |=> card_irq_o)
    else $error("unmasked source did not reach output");
  rst_gate_a: assert property (
    @(posedge clk_sys_i)
    $rose(rst_n_i) |-> gate_w)
    else $error("gate not set after reset");
  rst_rate_a: assert property (
    @(posedge clk_sys_i)
    $rose(rst_n_i) |-> rate_ff == `SDCLK_RATE_RST)
    else $error("rate register not at reset value");
  bus_ready_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    psel_i && !penable_i |=> pready_o)
    else $error("no ready in access phase");

endmodule : sdclk_bank

//--- sdclk_defs.svh
// offsets, field positions and reset values of the card host register bank
`ifndef SDCLK_DEFS_SVH
`define SDCLK_DEFS_SVH
`define SDCLK_OFS_IRQ_RAW 12'h000
`define SDCLK_OFS_IRQ_MASK 12'h004
`define SDCLK_OFS_IRQ_CLEAR 12'h008
`define SDCLK_OFS_CLK_RATE 12'h00c
`define SDCLK_OFS_IRQ_STATUS 12'h020
`define SDCLK_OFS_IRQ_ENABLE 12'h024
`define SDCLK_NUM_SRC 19
`define SDCLK_NUM_CLR 18
`define SDCLK_MASK_RST 19'h7ffff
`define SDCLK_RATE_RST 32'h80000000
`define SDCLK_GATE_BIT 31
`define SDCLK_DIV_MSB 15
`define SDCLK_DIV_RST 16'h0000
`define SDCLK_DIV_MIN 16'h0002
`define SDCLK_EV_GATE 0
`define SDCLK_EV_BADDIV 1
`define SDCLK_NUM_EV 2
`endif

//--- sdclk_pkg.sv
// types shared by the card host register bank
package sdclk_pkg;
  typedef enum logic [2:0] {
    SDCLK_GATED = 3'b001,
    SDCLK_HIGH = 3'b010,
    SDCLK_LOW = 3'b100
  } sdclk_state_e;
endpackage : sdclk_pkg

//--- sdclk_card_model.sv
// card side model: measures the phase lengths of the card serial clock
`timescale 1ns/100ps
module sdclk_card_model (
  input wire logic clk_sys_i,
  input wire logic card_clk_i,
  output int hi_len_o,
  output int lo_len_o
);
  int run_ff;
  logic prev_ff;
  // a phase closes on every level change; a card only sees the line
  always_ff @(posedge clk_sys_i) begin
    prev_ff <= card_clk_i;
    if (card_clk_i !== prev_ff) begin
      run_ff <= 1;
      if (prev_ff === 1'b1) hi_len_o <= run_ff;
      else lo_len_o <= run_ff;
    end else begin
      run_ff <= run_ff + 1;
    end
  end
endmodule : sdclk_card_model

//--- sdclk_bank_bench.sv
// self-checking bench for the raw clear and card clock register bank
`timescale 1ns/100ps
module sdclk_bank_bench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [18:0] src_event_i = 19'h0;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic [18:0] raw_irq_o;
  logic pready_o, pslverr_o, card_irq_o, card_clk_o, irq_o, err;
  int hi_len, lo_len;
  int fail_count = 0;
  int check_count = 0;

  // 40 MHz system clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  sdclk_bank i_sdclk_bank (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .src_event_i(src_event_i), .raw_irq_o(raw_irq_o),
    .card_irq_o(card_irq_o), .card_clk_o(card_clk_o), .irq_o(irq_o));

  sdclk_card_model i_sdclk_card_model (.clk_sys_i(clk_sys_i),
    .card_clk_i(card_clk_o), .hi_len_o(hi_len), .lo_len_o(lo_len));

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    rd = prdata_o;
    err = pslverr_o;
    if (pready_o !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // let registered outputs catch up, end mid-cycle
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h80000000);
    idle(1);
    chk(card_clk_o, 1'b0);
    apb(1'b0, 12'h100, 32'h0);
    chk(err, 1'b1);
    $display("test reset values done");
    @(posedge clk_sys_i);
    src_event_i <= 19'h7ffff;
    @(posedge clk_sys_i);
    src_event_i <= 19'h0;
    idle(3);
    chk(raw_irq_o, 19'h7ffff);
    chk(card_irq_o, 1'b0);
    apb(1'b1, 12'h008, 32'hfffc0005);
    idle(3);
    chk(raw_irq_o, 19'h7fffa);
    apb(1'b1, 12'h008, 32'h0003ffff);
    idle(3);
    chk(raw_irq_o, 19'h40000);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h004, 32'h3ffff);
    idle(3);
    chk(card_irq_o, 1'b1);
    apb(1'b1, 12'h004, 32'h7ffff);
    idle(3);
    chk(card_irq_o, 1'b0);
    $display("test raw clear done");
    // divider set while gated, only values of two or more
    apb(1'b1, 12'h00c, 32'h80000005);
    apb(1'b1, 12'h00c, 32'h00000005);
    idle(40);
    chk(hi_len, 2);
    chk(lo_len, 3);
    apb(1'b1, 12'h020, 32'h3);
    apb(1'b1, 12'h024, 32'h1);
    idle(3);
    chk(irq_o, 1'b0);
    apb(1'b1, 12'h00c, 32'h80000005);
    idle(3);
    chk(irq_o, 1'b1);
    repeat (6) begin
      idle(1);
      chk(card_clk_o, 1'b0);
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h80000005);
    apb(1'b1, 12'h024, 32'h0);
    idle(3);
    chk(irq_o, 1'b0);
    apb(1'b1, 12'h020, 32'h1);
    apb(1'b1, 12'h024, 32'h1);
    idle(3);
    chk(irq_o, 1'b0);
    apb(1'b1, 12'h00c, 32'h80000004);
    apb(1'b1, 12'h00c, 32'h00000004);
    idle(40);
    chk(hi_len, 2);
    chk(lo_len, 2);
    apb(1'b1, 12'h00c, 32'h80000004);
    apb(1'b1, 12'h00c, 32'h80000002);
    apb(1'b1, 12'h00c, 32'h00000002);
    idle(20);
    chk(hi_len, 1);
    chk(lo_len, 1);
    $display("test card clock done");
    wrap_up();
  end
endmodule : sdclk_bank_bench
